// ### common/lsd_pkg.sv
// lsd_pkg: constants and types of the legacy I/O space decoder
package lsd_pkg;
  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  localparam logic [11:0] ADC_OFFSET    = 12'h080;
  localparam logic [7:0]  ADC_RESET     = 8'h00;
  localparam int          UART1_DIS_BIT = 0;
  localparam int          UART2_DIS_BIT = 1;
  localparam int          RTC_DIS_BIT   = 2;
  localparam int          HOLE_DEST_BIT = 4;
  localparam logic [7:0]  ADC_RW_MASK   = 8'h17;
  localparam logic [7:0]  UNMAPPED_RD   = 8'h00;
  // ------------------------------------------------------------
  // legacy i/o map
  // ------------------------------------------------------------
  localparam logic [15:0] LEGACY_TOP  = 16'h03FF;
  localparam logic [15:0] DMAS_LO     = 16'h0000;
  localparam logic [15:0] DMAS_HI     = 16'h000F;
  localparam logic [15:0] ICM_LO      = 16'h0020;
  localparam logic [15:0] ICM_HI      = 16'h0021;
  localparam logic [15:0] IC2_LO      = 16'h0024;
  localparam logic [15:0] IC2_HI      = 16'h0025;
  localparam logic [15:0] TMR_LO      = 16'h0040;
  localparam logic [15:0] TMR_HI      = 16'h0043;
  localparam logic [15:0] KBD_DATA    = 16'h0060;
  localparam logic [15:0] SYS_CTL_B   = 16'h0061;
  localparam logic [15:0] KBD_CMD     = 16'h0064;
  localparam logic [15:0] RTC_LO      = 16'h0070;
  localparam logic [15:0] RTC_HI      = 16'h0071;
  localparam logic [15:0] SCR_A       = 16'h0080;
  localparam logic [15:0] PG_A_LO     = 16'h0081;
  localparam logic [15:0] PG_A_HI     = 16'h0083;
  localparam logic [15:0] SCR_B_LO    = 16'h0084;
  localparam logic [15:0] SCR_B_HI    = 16'h0086;
  localparam logic [15:0] PG_B        = 16'h0087;
  localparam logic [15:0] SCR_C       = 16'h0088;
  localparam logic [15:0] PG_C_LO     = 16'h0089;
  localparam logic [15:0] PG_C_HI     = 16'h008B;
  localparam logic [15:0] SCR_D_LO    = 16'h008C;
  localparam logic [15:0] SCR_D_HI    = 16'h008E;
  localparam logic [15:0] SCR_PRIV    = 16'h008F;
  localparam logic [15:0] SYS_CTL_A   = 16'h0092;
  localparam logic [15:0] IC1_LO      = 16'h00A0;
  localparam logic [15:0] IC1_HI      = 16'h00A1;
  localparam logic [15:0] DMAM_LO     = 16'h00C0;
  localparam logic [15:0] DMAM_HI     = 16'h00DE;
  localparam logic [15:0] FPERR_CLR   = 16'h00F0;
  localparam logic [15:0] UART2_LO    = 16'h02F8;
  localparam logic [15:0] UART2_HI    = 16'h02FF;
  localparam logic [15:0] UART1_LO    = 16'h03F8;
  localparam logic [15:0] UART1_HI    = 16'h03FF;
  localparam int          NUM_REGIONS = 4;
  localparam int          LANES       = 4;
  // ------------------------------------------------------------
  // destination of one cycle
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    LSD_DST_NONE    = 6'h01,
    LSD_DST_INT     = 6'h02,
    LSD_DST_INT_EXP = 6'h04,
    LSD_DST_EXP     = 6'h08,
    LSD_DST_PCI     = 6'h10,
    LSD_DST_REJECT  = 6'h20
  } lsd_dst_t;
endpackage : lsd_pkg

// ### common/lsd_dec_if.sv
// lsd_dec_if: decode signals between the top and its decoders
`timescale 1ns/1ps
`default_nettype none
interface lsd_dec_if;
  logic [15:0] byte_addr;
  logic [15:0] word_addr;
  logic [3:0]  be;
  logic        uart1_dis;
  logic        uart2_dis;
  logic        rtc_dis;
  logic        claim_int;
  logic        scratch;
  logic        kbd;
  logic        dis_ext;
  logic        rg_match;
  logic        rg_partial;
  modport top  (output byte_addr, word_addr, be, uart1_dis, uart2_dis,
                rtc_dis, input claim_int, scratch, kbd, dis_ext,
                rg_match, rg_partial);
  modport fixd (input byte_addr, uart1_dis, uart2_dis, rtc_dis,
                output claim_int, scratch, kbd, dis_ext);
  modport rgn  (input word_addr, be, output rg_match, rg_partial);
endinterface : lsd_dec_if
`default_nettype wire

// ### hw/lsd_fixed_dec.sv
// lsd_fixed_dec: fixed decode of the integrated legacy peripherals
`timescale 1ns/1ps
`default_nettype none
module lsd_fixed_dec (
  lsd_dec_if.fixd dif
);
  function automatic logic in_rng(input logic [15:0] a,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  logic [15:0] a;
  logic        uart_hit1;
  logic        uart_hit2;
  logic        rtc_hit;

  always_comb begin
    a         = dif.byte_addr;
    uart_hit1 = in_rng(a, lsd_pkg::UART1_LO, lsd_pkg::UART1_HI);
    uart_hit2 = in_rng(a, lsd_pkg::UART2_LO, lsd_pkg::UART2_HI);
    rtc_hit   = in_rng(a, lsd_pkg::RTC_LO, lsd_pkg::RTC_HI);
    dif.kbd   = (a == lsd_pkg::KBD_DATA) || (a == lsd_pkg::KBD_CMD);
    dif.scratch = (a == lsd_pkg::SCR_A) || (a == lsd_pkg::SCR_C)
                || in_rng(a, lsd_pkg::SCR_B_LO, lsd_pkg::SCR_B_HI)
                || in_rng(a, lsd_pkg::SCR_D_LO, lsd_pkg::SCR_D_HI);
    dif.claim_int =
         in_rng(a, lsd_pkg::DMAS_LO, lsd_pkg::DMAS_HI)
      || in_rng(a, lsd_pkg::ICM_LO, lsd_pkg::ICM_HI)
      || in_rng(a, lsd_pkg::IC2_LO, lsd_pkg::IC2_HI)
      || in_rng(a, lsd_pkg::IC1_LO, lsd_pkg::IC1_HI)
      || (in_rng(a, lsd_pkg::DMAM_LO, lsd_pkg::DMAM_HI) && !a[0])
      || in_rng(a, lsd_pkg::TMR_LO, lsd_pkg::TMR_HI)
      || (a == lsd_pkg::SYS_CTL_B) || (a == lsd_pkg::SCR_PRIV)
      || in_rng(a, lsd_pkg::PG_A_LO, lsd_pkg::PG_A_HI)
      || (a == lsd_pkg::PG_B)
      || in_rng(a, lsd_pkg::PG_C_LO, lsd_pkg::PG_C_HI)
      || (a == lsd_pkg::SYS_CTL_A) || (a == lsd_pkg::FPERR_CLR)
      || (rtc_hit && !dif.rtc_dis)
      || (uart_hit1 && !dif.uart1_dis)
      || (uart_hit2 && !dif.uart2_dis);
    dif.dis_ext = (rtc_hit && dif.rtc_dis)
                || (uart_hit1 && dif.uart1_dis)
                || (uart_hit2 && dif.uart2_dis);
  end
endmodule : lsd_fixed_dec
`default_nettype wire

// ### hw/lsd_region_match.sv
// lsd_region_match: byte-granular match against the region registers
`timescale 1ns/1ps
`default_nettype none
module lsd_region_match #(
  parameter int N = 4
) (
  lsd_dec_if.rgn             dif,
  input  wire logic [N-1:0]    rgn_en,
  input  wire logic [N*16-1:0] rgn_start,
  input  wire logic [N*16-1:0] rgn_end
);
  logic [15:0] ba;
  logic [15:0] lo;
  logic [15:0] hi;
  logic        any_in;
  logic        all_in;
  logic        in_r;

  always_comb begin
    ba = '0;
    lo = '0;
    hi = '0;
    any_in = 1'b0;
    all_in = 1'b1;
    in_r = 1'b0;
    dif.rg_match   = 1'b0;
    dif.rg_partial = 1'b0;
    for (int r = 0; r < N; r++) begin
      lo = rgn_start[r*16 +: 16];
      hi = rgn_end[r*16 +: 16];
      any_in = 1'b0;
      all_in = 1'b1;
      for (int b = 0; b < lsd_pkg::LANES; b++) begin
        ba   = {dif.word_addr[15:2], 2'(b)};
        in_r = (ba >= lo) && (ba <= hi);
        if (dif.be[b]) begin
          any_in = any_in | in_r;
          all_in = all_in & in_r;
        end
      end
      if (rgn_en[r] && any_in && all_in) begin
        dif.rg_match = 1'b1;
      end
      if (rgn_en[r] && any_in && !all_in) begin
        dif.rg_partial = 1'b1;
      end
    end
  end
endmodule : lsd_region_match
`default_nettype wire

// ### hw/lsd_io_decoder.sv
// lsd_io_decoder: top of the legacy lower 1-Kbyte i/o space decoder
`timescale 1ns/1ps
`default_nettype none
module lsd_io_decoder #(
  parameter int N = lsd_pkg::NUM_REGIONS
) (
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  input  wire logic              io_req,
  input  wire logic [15:0]       io_addr,
  input  wire logic [3:0]        io_be,
  input  wire logic              io_write,
  input  wire logic              io_from_pci,
  input  wire logic              cfg_wr,
  input  wire logic              cfg_rd,
  input  wire logic [11:0]       cfg_addr,
  input  wire logic [7:0]        cfg_wdata,
  input  wire logic [N-1:0]      rgn_en,
  input  wire logic [N*16-1:0]   rgn_start,
  input  wire logic [N*16-1:0]   rgn_end,
  output logic                   dst_valid,
  output lsd_pkg::lsd_dst_t      dst_code,
  output logic                   kbd_snoop,
  output logic [7:0]             cfg_rdata
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]        ctl;
    logic              valid;
    lsd_pkg::lsd_dst_t dst;
    logic              snoop;
    logic [7:0]        rdata;
  } lsd_state_t;

  lsd_state_t  st_ff;
  lsd_state_t  nxt_st;
  logic [15:0] byte_addr;
  logic        hole_dest;
  logic        in_legacy;

  lsd_dec_if dif ();

  // ------------------------------------------------------------
  // lowest enabled byte of the cycle
  // ------------------------------------------------------------
  always_comb begin
    byte_addr = {io_addr[15:2], 2'b00};
    for (int i = lsd_pkg::LANES - 1; i >= 0; i--) begin
      if (io_be[i]) begin
        byte_addr = {io_addr[15:2], 2'(i)};
      end
    end
  end

  assign hole_dest     = st_ff.ctl[lsd_pkg::HOLE_DEST_BIT];
  assign in_legacy     = byte_addr <= lsd_pkg::LEGACY_TOP;
  assign dif.byte_addr = byte_addr;
  assign dif.word_addr = io_addr;
  assign dif.be        = io_be;
  assign dif.uart1_dis = st_ff.ctl[lsd_pkg::UART1_DIS_BIT];
  assign dif.uart2_dis = st_ff.ctl[lsd_pkg::UART2_DIS_BIT];
  assign dif.rtc_dis   = st_ff.ctl[lsd_pkg::RTC_DIS_BIT];

  // ------------------------------------------------------------
  // decoders
  // ------------------------------------------------------------
  lsd_fixed_dec u_fixed (
    .dif (dif)
  );

  lsd_region_match #(
    .N (N)
  ) u_region (
    .dif       (dif),
    .rgn_en    (rgn_en),
    .rgn_start (rgn_start),
    .rgn_end   (rgn_end)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.valid = io_req;
    nxt_st.snoop = 1'b0;
    if (cfg_wr && (cfg_addr == lsd_pkg::ADC_OFFSET)) begin
      nxt_st.ctl = cfg_wdata & lsd_pkg::ADC_RW_MASK;
    end
    if (cfg_rd) begin
      nxt_st.rdata = (cfg_addr == lsd_pkg::ADC_OFFSET) ? st_ff.ctl
                                                      : lsd_pkg::UNMAPPED_RD;
    end
    if (!io_req) begin
      nxt_st.dst = lsd_pkg::LSD_DST_NONE;
    end else if (io_from_pci) begin
      nxt_st.dst = lsd_pkg::LSD_DST_REJECT;
    end else if (dif.kbd) begin
      nxt_st.dst   = lsd_pkg::LSD_DST_EXP;
      nxt_st.snoop = 1'b1;
    end else if (dif.scratch) begin
      nxt_st.dst = io_write ? lsd_pkg::LSD_DST_INT_EXP
                            : lsd_pkg::LSD_DST_INT;
    end else if (dif.claim_int) begin
      nxt_st.dst = lsd_pkg::LSD_DST_INT;
    end else if (dif.dis_ext) begin
      nxt_st.dst = lsd_pkg::LSD_DST_EXP;
    end else if (dif.rg_partial) begin
      nxt_st.dst = lsd_pkg::LSD_DST_PCI;
    end else if (dif.rg_match) begin
      nxt_st.dst = lsd_pkg::LSD_DST_EXP;
    end else if (in_legacy) begin
      nxt_st.dst = hole_dest ? lsd_pkg::LSD_DST_PCI
                             : lsd_pkg::LSD_DST_EXP;
    end else begin
      nxt_st.dst = lsd_pkg::LSD_DST_PCI;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '{ctl:   lsd_pkg::ADC_RESET,
                 valid: 1'b0,
                 dst:   lsd_pkg::LSD_DST_NONE,
                 snoop: 1'b0,
                 rdata: lsd_pkg::UNMAPPED_RD};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dst_valid = st_ff.valid;
  assign dst_code  = st_ff.dst;
  assign kbd_snoop = st_ff.snoop;
  assign cfg_rdata = st_ff.rdata;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_pci_master_out: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && io_from_pci |=> dst_valid && !kbd_snoop
      && dst_code == lsd_pkg::LSD_DST_REJECT)
    else $error("pci master cycle not rejected");

  a_kbd_snoop_ext: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && !io_from_pci && (byte_addr == lsd_pkg::KBD_CMD
      || byte_addr == lsd_pkg::KBD_DATA)
    |=> kbd_snoop && dst_code == lsd_pkg::LSD_DST_EXP)
    else $error("keyboard port not forwarded and snooped");

  a_port61_only: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && !io_from_pci && byte_addr == lsd_pkg::SYS_CTL_B
    |=> dst_code == lsd_pkg::LSD_DST_INT)
    else $error("port 61h left the chip");

  a_scratch_split: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && !io_from_pci && byte_addr == lsd_pkg::SCR_A
    |=> dst_code == ($past(io_write) ? lsd_pkg::LSD_DST_INT_EXP
                                     : lsd_pkg::LSD_DST_INT))
    else $error("scratch port routed wrongly");

  a_scratch_priv: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && !io_from_pci && byte_addr == lsd_pkg::SCR_PRIV
    |=> dst_code == lsd_pkg::LSD_DST_INT)
    else $error("port 8fh left the chip");

  a_page_internal: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && !io_from_pci && (byte_addr == lsd_pkg::PG_B
      || byte_addr == lsd_pkg::PG_A_LO)
    |=> dst_code == lsd_pkg::LSD_DST_INT)
    else $error("page register left the chip");

  a_hole_route: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && !io_from_pci && in_legacy && !dif.claim_int
      && !dif.scratch && !dif.kbd && !dif.dis_ext
      && !dif.rg_match && !dif.rg_partial
    |=> dst_code == ($past(hole_dest) ? lsd_pkg::LSD_DST_PCI
                                      : lsd_pkg::LSD_DST_EXP))
    else $error("hole routed against destination bit");

  a_uart_disabled: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && !io_from_pci && byte_addr == lsd_pkg::UART1_LO
      && dif.uart1_dis
    |=> dst_code == lsd_pkg::LSD_DST_EXP)
    else $error("disabled uart not sent external");

  a_partial_pci: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && !io_from_pci && in_legacy && dif.rg_partial
      && !dif.claim_int && !dif.scratch && !dif.kbd && !dif.dis_ext
    |=> dst_code == lsd_pkg::LSD_DST_PCI)
    else $error("partial region access not sent to pci");

  a_one_dest: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req |=> dst_valid ##1 (dst_valid == $past(io_req))
      && $onehot(dst_code))
    else $error("destination not unique or late");

  a_dma_slave: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && !io_from_pci && byte_addr <= lsd_pkg::DMAS_HI
    |=> dst_code == lsd_pkg::LSD_DST_INT)
    else $error("slave dma port not claimed");

  a_dma_master_even: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && !io_from_pci && byte_addr >= lsd_pkg::DMAM_LO
      && byte_addr <= lsd_pkg::DMAM_HI && !byte_addr[0]
    |=> dst_code == lsd_pkg::LSD_DST_INT)
    else $error("even master dma port not claimed");

  a_dma_master_odd: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && !io_from_pci && byte_addr >= lsd_pkg::DMAM_LO
      && byte_addr <= lsd_pkg::DMAM_HI && byte_addr[0]
    |=> dst_code != lsd_pkg::LSD_DST_INT)
    else $error("odd master dma port claimed");

  a_intc_claim: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && !io_from_pci
      && ((byte_addr >= lsd_pkg::ICM_LO && byte_addr <= lsd_pkg::ICM_HI)
      || (byte_addr >= lsd_pkg::IC2_LO && byte_addr <= lsd_pkg::IC2_HI)
      || (byte_addr >= lsd_pkg::IC1_LO && byte_addr <= lsd_pkg::IC1_HI))
    |=> dst_code == lsd_pkg::LSD_DST_INT)
    else $error("interrupt controller port not claimed");

  a_timer_claim: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && !io_from_pci && byte_addr >= lsd_pkg::TMR_LO
      && byte_addr <= lsd_pkg::TMR_HI
    |=> dst_code == lsd_pkg::LSD_DST_INT)
    else $error("timer port not claimed");

  a_rtc_route: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && !io_from_pci && byte_addr >= lsd_pkg::RTC_LO
      && byte_addr <= lsd_pkg::RTC_HI
    |=> dst_code == ($past(dif.rtc_dis) ? lsd_pkg::LSD_DST_EXP
                                        : lsd_pkg::LSD_DST_INT))
    else $error("rtc port routed against its disable bit");

  a_uart_enabled: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && !io_from_pci
      && ((byte_addr >= lsd_pkg::UART1_LO && byte_addr <= lsd_pkg::UART1_HI
          && !dif.uart1_dis)
      || (byte_addr >= lsd_pkg::UART2_LO && byte_addr <= lsd_pkg::UART2_HI
          && !dif.uart2_dis))
    |=> dst_code == lsd_pkg::LSD_DST_INT)
    else $error("enabled uart port not claimed");

  a_ctl_ports: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && !io_from_pci && (byte_addr == lsd_pkg::SYS_CTL_A
      || byte_addr == lsd_pkg::FPERR_CLR)
    |=> dst_code == lsd_pkg::LSD_DST_INT)
    else $error("control port a or fp error clear not claimed");

  a_page_ranges: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && !io_from_pci
      && ((byte_addr >= lsd_pkg::PG_A_LO && byte_addr <= lsd_pkg::PG_A_HI)
      || (byte_addr >= lsd_pkg::PG_C_LO && byte_addr <= lsd_pkg::PG_C_HI))
    |=> dst_code == lsd_pkg::LSD_DST_INT)
    else $error("page register range left the chip");

  a_scratch_other: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && !io_from_pci && (byte_addr == lsd_pkg::SCR_C
      || (byte_addr >= lsd_pkg::SCR_B_LO && byte_addr <= lsd_pkg::SCR_B_HI)
      || (byte_addr >= lsd_pkg::SCR_D_LO && byte_addr <= lsd_pkg::SCR_D_HI))
    |=> dst_code == ($past(io_write) ? lsd_pkg::LSD_DST_INT_EXP
                                     : lsd_pkg::LSD_DST_INT))
    else $error("scratch range routed wrongly");

  a_region_full: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && !io_from_pci && dif.rg_match && !dif.rg_partial
      && !dif.claim_int && !dif.scratch && !dif.kbd && !dif.dis_ext
    |=> dst_code == lsd_pkg::LSD_DST_EXP)
    else $error("region access not sent to expansion bus");

  a_above_legacy: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && !io_from_pci && !in_legacy && !dif.rg_match
      && !dif.rg_partial
    |=> dst_code == lsd_pkg::LSD_DST_PCI)
    else $error("plain cpu i/o not sent to pci");

  a_pci_no_region: assert property (@(posedge core_clk) disable iff (!arst_n)
    io_req && io_from_pci && dif.rg_match
    |=> dst_code != lsd_pkg::LSD_DST_EXP)
    else $error("pci master cycle entered a region");

  a_idle_none: assert property (@(posedge core_clk) disable iff (!arst_n)
    !io_req |=> !dst_valid && dst_code == lsd_pkg::LSD_DST_NONE)
    else $error("destination shown with no cycle");
endmodule : lsd_io_decoder
`default_nettype wire

// ### test/lsd_cpu_model.sv
// lsd_cpu_model: cpu core issuing legacy i/o cycles
`timescale 1ns/1ps
`default_nettype none
module lsd_cpu_model (
  input  wire logic   core_clk,
  output logic        io_req,
  output logic [15:0] io_addr,
  output logic [3:0]  io_be,
  output logic        io_write,
  output logic        io_from_pci
);
  initial begin
    io_req      = 1'b0;
    io_addr     = 16'h0000;
    io_be       = 4'h0;
    io_write    = 1'b0;
    io_from_pci = 1'b0;
  end
  // one cycle per edge, back to back allowed
  task automatic cycle(input logic [15:0] a, input logic [3:0] be,
                       input logic wr, input logic pci);
    @(posedge core_clk);
    io_req      <= 1'b1;
    io_addr     <= a;
    io_be       <= be;
    io_write    <= wr;
    io_from_pci <= pci;
  endtask : cycle
  // released lines show changing garbage
  task automatic idle();
    @(posedge core_clk);
    io_req      <= 1'b0;
    io_addr     <= ~io_addr;
    io_be       <= ~io_be;
    io_write    <= ~io_write;
    io_from_pci <= ~io_from_pci;
  endtask : idle
endmodule : lsd_cpu_model
`default_nettype wire

// ### test/legacy_io_space_decoder_bench.sv
// legacy_io_space_decoder_bench: self-checking bench of the decoder
`timescale 1ns/1ps
`default_nettype none
module legacy_io_space_decoder_bench;
  logic core_clk = 1'b0, arst_n = 1'b0, io_req, io_write, io_from_pci;
  logic [15:0] io_addr;
  logic [3:0] io_be, rgn_en = 4'h0;
  logic cfg_wr = 1'b0, cfg_rd = 1'b0, dst_valid, kbd_snoop;
  logic [11:0] cfg_addr = 12'h000;
  logic [7:0] cfg_wdata = 8'h00, cfg_rdata, ctrl_m = 8'h00, rd_exp = 8'h00;
  logic [63:0] rgn_start = 64'h0, rgn_end = 64'h0;
  lsd_pkg::lsd_dst_t dst_code;
  logic [5:0] exp_code = 6'h01;
  logic exp_v = 1'b0, exp_snoop = 1'b0;
  int bad_count = 0, checks_done = 0, seed = 32'h6e04d29f, a, i;
  logic [7:0] ctrl_vals [4] = '{8'h00, 8'h10, 8'h07, 8'hFF};
  always #50 core_clk = ~core_clk;
  lsd_cpu_model u_lsd_cpu_model (.core_clk(core_clk), .io_req(io_req),
    .io_addr(io_addr), .io_be(io_be), .io_write(io_write),
    .io_from_pci(io_from_pci));
  lsd_io_decoder #(.N(4)) u_lsd_io_decoder (.core_clk(core_clk),
    .arst_n(arst_n), .io_req(io_req), .io_addr(io_addr), .io_be(io_be),
    .io_write(io_write), .io_from_pci(io_from_pci), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .rgn_en(rgn_en), .rgn_start(rgn_start), .rgn_end(rgn_end),
    .dst_valid(dst_valid), .dst_code(dst_code), .kbd_snoop(kbd_snoop),
    .cfg_rdata(cfg_rdata));
  // ------------------------------------------------------------
  // reference model
  // ------------------------------------------------------------
  function automatic logic [5:0] ref_code(logic [15:0] ad, logic [3:0] be,
                                          logic wr, logic pci);
    int b, lo, n, hit, part, full, ba;
    lo = 0; part = 0; full = 0;
    while (lo < 3 && !be[lo]) lo++;
    b = {ad[15:2], 2'b00} + lo;
    if (pci) return 6'h20;
    if (b == 'h60 || b == 'h64) return 6'h08;
    if (b == 'h80 || (b >= 'h84 && b <= 'h86) || b == 'h88 ||
        (b >= 'h8C && b <= 'h8E)) return wr ? 6'h04 : 6'h02;
    if ((b >= 'h3F8 && b <= 'h3FF && ctrl_m[0]) ||
        (b >= 'h2F8 && b <= 'h2FF && ctrl_m[1]) ||
        (b >= 'h70 && b <= 'h71 && ctrl_m[2])) return 6'h08;
    if (b <= 'hF || b == 'h20 || b == 'h21 || b == 'h24 || b == 'h25 ||
        (b >= 'h40 && b <= 'h43) || b == 'h61 || b == 'h70 || b == 'h71 ||
        (b >= 'h81 && b <= 'h83) || b == 'h87 || (b >= 'h89 && b <= 'h8B)
        || b == 'h8F || b == 'h92 || b == 'hA0 || b == 'hA1 || b == 'hF0 ||
        (b >= 'hC0 && b <= 'hDE && b % 2 == 0) || (b >= 'h2F8 && b <= 'h2FF)
        || (b >= 'h3F8 && b <= 'h3FF))
      return 6'h02;
    for (int r = 0; r < 4; r++) begin // above
      n = 0;
      hit = 0;
      for (int l = 0; l < 4; l++) begin
        ba = {ad[15:2], 2'b00} + l;
        n += be[l];
        hit += be[l] && rgn_en[r] && ba >= rgn_start[r*16+:16] &&
               ba <= rgn_end[r*16+:16];
      end
      if (hit > 0 && hit < n) part = 1;
      if (hit > 0 && hit == n) full = 1;
    end
    if (part) return 6'h10;
    if (full) return 6'h08;
    if (b <= 'h3FF) return ctrl_m[4] ? 6'h10 : 6'h08;
    return 6'h10;
  endfunction : ref_code
  always @(posedge core_clk) begin
    exp_v     <= arst_n && io_req;
    exp_code  <= (arst_n && io_req) ?
                 ref_code(io_addr, io_be, io_write, io_from_pci) : 6'h01;
    exp_snoop <= arst_n && io_req && !io_from_pci &&
                 ref_code(io_addr, io_be, 1'b0, 1'b0) == 6'h08 &&
                 (({io_addr[15:2], 2'b00} + (io_be[0] ? 0 : io_be[1] ? 1 :
                 io_be[2] ? 2 : 3)) % 'h10000 inside {'h60, 'h64});
    if (arst_n && cfg_wr && cfg_addr === 12'h080) ctrl_m <= cfg_wdata & 8'h17;
    if (arst_n && cfg_rd) rd_exp <= (cfg_addr === 12'h080) ? ctrl_m : 8'h00;
  end
  // ------------------------------------------------------------
  // compare and close
  // ------------------------------------------------------------
  task automatic chk_dst();
    checks_done++;
    if (dst_valid !== exp_v || dst_code !== exp_code ||
        kbd_snoop !== exp_snoop) begin
      bad_count++;
      $display("Error %0t dst %h exp %h at %h", $time, dst_code, exp_code,
               io_addr);
    end
  endtask : chk_dst
  task automatic chk_cfg();
    checks_done++;
    if (cfg_rdata !== rd_exp) begin
      bad_count++;
      $display("Error %0t cfg read %h exp %h", $time, cfg_rdata, rd_exp);
    end
  endtask : chk_cfg
  always @(negedge core_clk) begin
    chk_dst();
    chk_cfg();
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic cfg(input logic wr, input logic [11:0] ad,
                     input logic [7:0] d);
    @(posedge core_clk);
    cfg_wr    <= wr;
    cfg_rd    <= !wr;
    cfg_addr  <= ad;
    cfg_wdata <= d;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
  endtask : cfg
  initial begin
    repeat (100000) @(posedge core_clk);
    bad_count++;
    close_out();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    cfg(1'b0, 12'h080, 8'h00);
    cfg(1'b1, 12'h081, 8'hFF);
    cfg(1'b0, 12'h081, 8'h00);
    foreach (ctrl_vals[k]) begin
      cfg(1'b1, 12'h080, ctrl_vals[k]);
      cfg(1'b0, 12'h080, 8'h00);
      for (a = 0; a < 'h410; a++)
        for (i = 0; i < 2; i++)
          u_lsd_cpu_model.cycle(a[15:0], 4'h1 << a[1:0], i[0], 1'b0);
      u_lsd_cpu_model.idle();
    end
    // region partly hit by a word access, exact byte access
    @(posedge core_clk);
    rgn_en    <= 4'h1;
    rgn_start <= 64'h0301;
    rgn_end   <= 64'h0303;
    u_lsd_cpu_model.cycle(16'h0300, 4'h3, 1'b0, 1'b0);
    u_lsd_cpu_model.cycle(16'h0301, 4'h2, 1'b1, 1'b0);
    u_lsd_cpu_model.cycle(16'h0300, 4'hE, 1'b0, 1'b0);
    for (i = 0; i < 3000; i++) begin
      if (i % 200 == 0) begin
        cfg(1'b1, 12'h080, $random(seed));
        @(posedge core_clk);
        rgn_en <= $random(seed);
        // regions kept clear of internal ports
        for (int r = 0; r < 4; r++) begin
          a = 'h100 * (r + 1) + {$random(seed)} % 'hF0;
          rgn_start[r*16+:16] <= a[15:0];
          rgn_end[r*16+:16]   <= a[15:0] + {$random(seed)} % 8;
        end
      end
      u_lsd_cpu_model.cycle({$random(seed)} % 'h800, {$random(seed)} % 15 + 1,
                            $random(seed), {$random(seed)} % 8 == 0);
    end
    u_lsd_cpu_model.idle();
    repeat (3) @(posedge core_clk);
    close_out();
  end
endmodule : legacy_io_space_decoder_bench
`default_nettype wire
